/* File: bca_pkg.sv */
// Purpose : Shared constants and carriers for the bytecode accelerator config registers
// Assumes : Coprocessor transfers arrive as one-cycle requests on the core clock
// Notes   : Register selection follows the coprocessor opcode fields
`default_nettype none
package bca_pkg;

   // ==========================================================
   // Coprocessor selection
   localparam logic [3:0]  CP_NUM        = 4'hE;
   localparam logic [2:0]  CP_OP1        = 3'h7;
   localparam logic [3:0]  CRN_MAIN      = 4'h2;
   localparam logic [3:0]  CRN_PARAMS    = 4'h3;
   localparam logic [3:0]  CRM_SEL       = 4'h0;
   localparam logic [2:0]  CP_OP2        = 3'h0;

   // ==========================================================
   // Main config fields
   localparam int          MC_ARRAY_BIT  = 31;
   localparam int          MC_FLOAT_BIT  = 30;
   localparam int          MC_APTR_BIT   = 29;
   localparam int          MC_OPTR_BIT   = 28;
   localparam int          MC_IDX_BIT    = 27;
   localparam int          MC_SPTR_BIT   = 26;
   localparam int          MC_EN_BIT     = 0;
   localparam logic [31:0] MC_WR_MASK    = 32'hBC000001;
   localparam logic [31:0] MC_RESET      = 32'h00000000;

   // ==========================================================
   // Parameter fields
   localparam logic [31:0] PR_WR_MASK    = 32'h003FFFFF;
   localparam logic [31:0] PR_RESET      = 32'h00000000;
   localparam int          PR_BSH_LSB    = 17;
   localparam int          PR_DSC_LSB    = 12;
   localparam int          PR_ARO_LSB    = 8;
   localparam int          PR_STO_LSB    = 4;
   localparam int          PR_ODO_LSB    = 0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        privileged;
      logic [3:0]  cp_num;
      logic [2:0]  op1;
      logic [3:0]  crn;
      logic [3:0]  crm;
      logic [2:0]  op2;
      logic [31:0] wdata;
   } bca_req_s;

   typedef struct packed {
      logic        array_ops_to_handlers;
      logic        float_via_coprocessor;
      logic        array_pointer_mode;
      logic        object_ref_pointer;
      logic        field_index_wide;
      logic        static_ref_pointer;
      logic        hw_accel_enable;
      logic [4:0]  bound_count_shift;
      logic [4:0]  descriptor_word_offset;
      logic [3:0]  array_data_offset;
      logic [3:0]  static_field_offset;
      logic [3:0]  object_field_offset;
   } bca_cfg_s;

   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_EXCHANGE,
      MODE_BYTECODE,
      MODE_DISABLED_EXC
   } bca_entry_e;

endpackage : bca_pkg
`default_nettype wire

/* File: bca_decode.sv */
// Purpose : Decodes a coprocessor transfer into register selects
// Assumes : Request fields are stable while valid
// Notes   : Combinational
`timescale 1ns/10ps
`default_nettype none
module bca_decode (
   input  wire bca_pkg::bca_req_s i_req,
   output logic                   o_sel_main,
   output logic                   o_sel_params,
   output logic                   o_undef
);
   import bca_pkg::*;
   logic hit;
   always_comb begin
      hit = i_req.valid && i_req.cp_num == CP_NUM && i_req.op1 == CP_OP1 &&
            i_req.crm == CRM_SEL && i_req.op2 == CP_OP2;
      o_sel_main   = hit && i_req.privileged && i_req.crn == CRN_MAIN;
      o_sel_params = hit && i_req.privileged && i_req.crn == CRN_PARAMS;
      o_undef      = hit && !i_req.privileged &&
                     (i_req.crn == CRN_MAIN || i_req.crn == CRN_PARAMS);
   end
endmodule : bca_decode
`default_nettype wire

/* File: bca_entry.sv */
// Purpose : Resolves bytecode-entry requests against the enable bit
// Assumes : One request per cycle
// Notes   : Registered result
`timescale 1ns/10ps
`default_nettype none
module bca_entry (
   input  wire logic                i_clk,
   input  wire logic                i_reset,
   input  wire logic                i_enable,
   input  wire logic                i_branch_enter_bytecode,
   input  wire logic                i_set_status_flag,
   output var  bca_pkg::bca_entry_e o_result
);
   import bca_pkg::*;
   bca_entry_e state;
   bca_entry_e next_state;
   always_comb begin
      next_state = MODE_NONE;
      if (i_enable && (i_branch_enter_bytecode || i_set_status_flag)) begin
         next_state = MODE_BYTECODE;
      end else if (!i_enable && i_set_status_flag) begin
         next_state = MODE_DISABLED_EXC;
      end else if (!i_enable && i_branch_enter_bytecode) begin
         next_state = MODE_EXCHANGE;
      end
   end
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state <= MODE_NONE;
      end else begin
         state <= next_state;
      end
   end
   assign o_result = state;
endmodule : bca_entry
`default_nettype wire

/* File: bca_config_regs.sv */
// Purpose : Main configuration and parameter registers of the bytecode accelerator
// Assumes : Transfers are one-cycle requests; read data returns next cycle
// Notes   : Config outputs update only outside bytecode execution
`timescale 1ns/10ps
`default_nettype none
module bca_config_regs (
   input  wire logic                i_clk,
   input  wire logic                i_reset,
   input  wire bca_pkg::bca_req_s   i_req,
   input  wire logic                i_bytecode_active,
   input  wire logic                i_branch_enter_bytecode,
   input  wire logic                i_set_status_flag,
   output logic [31:0]              o_rdata,
   output logic                     o_rvalid,
   output logic                     o_undef,
   output bca_pkg::bca_cfg_s        o_cfg,
   output bca_pkg::bca_entry_e      o_entry
);
   import bca_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [31:0] main_cfg;
      logic [31:0] params;
      logic [31:0] rdata;
      logic        rvalid;
      logic        undef;
      bca_cfg_s    cfg;
   } bca_state_s;

   bca_state_s st;
   bca_state_s next_st;
   logic       sel_main;
   logic       sel_params;
   logic       undef_req;
   logic       enable_live;

   bca_decode u_decode (
      .i_req        (i_req),
      .o_sel_main   (sel_main),
      .o_sel_params (sel_params),
      .o_undef      (undef_req)
   );

   bca_entry u_entry (
      .i_clk                   (i_clk),
      .i_reset                 (i_reset),
      .i_enable                (enable_live),
      .i_branch_enter_bytecode (i_branch_enter_bytecode),
      .i_set_status_flag       (i_set_status_flag),
      .o_result                (o_entry)
   );

   assign enable_live = st.cfg.hw_accel_enable;

   // ==========================================================
   // Next state
   always_comb begin
      next_st        = st;
      next_st.rvalid = 1'b0;
      next_st.undef  = undef_req;
      if (sel_main && i_req.write) begin
         next_st.main_cfg = i_req.wdata & MC_WR_MASK;
      end
      if (sel_params && i_req.write) begin
         next_st.params = i_req.wdata & PR_WR_MASK;
      end
      if ((sel_main || sel_params) && !i_req.write) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = sel_main ? st.main_cfg : st.params;
      end
      if (!i_bytecode_active) begin
         next_st.cfg.array_ops_to_handlers  = next_st.main_cfg[MC_ARRAY_BIT];
         next_st.cfg.float_via_coprocessor  = next_st.main_cfg[MC_FLOAT_BIT];
         next_st.cfg.array_pointer_mode     = next_st.main_cfg[MC_APTR_BIT];
         next_st.cfg.object_ref_pointer     = next_st.main_cfg[MC_OPTR_BIT];
         next_st.cfg.field_index_wide       = next_st.main_cfg[MC_IDX_BIT];
         next_st.cfg.static_ref_pointer     = next_st.main_cfg[MC_SPTR_BIT];
         next_st.cfg.hw_accel_enable        = next_st.main_cfg[MC_EN_BIT];
         next_st.cfg.bound_count_shift      = next_st.params[PR_BSH_LSB +: 5];
         next_st.cfg.descriptor_word_offset = next_st.params[PR_DSC_LSB +: 5];
         next_st.cfg.array_data_offset      = next_st.params[PR_ARO_LSB +: 4];
         next_st.cfg.static_field_offset    = next_st.params[PR_STO_LSB +: 4];
         next_st.cfg.object_field_offset    = next_st.params[PR_ODO_LSB +: 4];
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st          <= '0;
         st.main_cfg <= MC_RESET;
         st.params   <= PR_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata  = st.rdata;
   assign o_rvalid = st.rvalid;
   assign o_undef  = st.undef;
   assign o_cfg    = st.cfg;

   // ==========================================================
   // Assertions
   // float bit never set
   property p_float_zero;
      @(posedge i_clk) disable iff (i_reset)
         !st.main_cfg[MC_FLOAT_BIT] && !o_cfg.float_via_coprocessor;
   endproperty
   a_float_zero: assert property (p_float_zero) else $error("float bit set");

   property p_reserved_zero;
      @(posedge i_clk) disable iff (i_reset)
         (st.main_cfg & ~MC_WR_MASK) == 32'h0 && (st.params & ~PR_WR_MASK) == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_user_undef;
      @(posedge i_clk) disable iff (i_reset)
         (i_req.valid && !i_req.privileged && i_req.cp_num == CP_NUM && i_req.op1 == CP_OP1
          && i_req.crn == CRN_MAIN && i_req.crm == CRM_SEL && i_req.op2 == CP_OP2)
         |=> o_undef && !o_rvalid;
   endproperty
   a_user_undef: assert property (p_user_undef) else $error("user access not trapped");

   property p_user_no_write;
      @(posedge i_clk) disable iff (i_reset)
         (i_req.valid && !i_req.privileged) |=> $stable(st.main_cfg) && $stable(st.params);
   endproperty
   a_user_no_write: assert property (p_user_no_write) else $error("user write landed");

   property p_main_write;
      @(posedge i_clk) disable iff (i_reset)
         (sel_main && i_req.write) |=> st.main_cfg == ($past(i_req.wdata) & MC_WR_MASK);
   endproperty
   a_main_write: assert property (p_main_write) else $error("main write lost");

   property p_params_read;
      @(posedge i_clk) disable iff (i_reset)
         (sel_params && !i_req.write) |=> o_rvalid && o_rdata == $past(st.params);
   endproperty
   a_params_read: assert property (p_params_read) else $error("params read wrong");

   property p_hold_active;
      @(posedge i_clk) disable iff (i_reset) i_bytecode_active |=> $stable(o_cfg);
   endproperty
   a_hold_active: assert property (p_hold_active) else $error("cfg changed mid-run");

   property p_array_follow;
      @(posedge i_clk) disable iff (i_reset)
         !i_bytecode_active |=> o_cfg.array_ops_to_handlers == st.main_cfg[MC_ARRAY_BIT]
            && o_cfg.array_pointer_mode == st.main_cfg[MC_APTR_BIT];
   endproperty
   a_array_follow: assert property (p_array_follow) else $error("array cfg stale");

   property p_offsets;
      @(posedge i_clk) disable iff (i_reset)
         !i_bytecode_active |=> o_cfg.descriptor_word_offset == st.params[16:12]
            && o_cfg.bound_count_shift == st.params[21:17]
            && o_cfg.object_field_offset == st.params[3:0];
   endproperty
   a_offsets: assert property (p_offsets) else $error("offset fields stale");

   property p_disabled_trap;
      @(posedge i_clk) disable iff (i_reset)
         (!o_cfg.hw_accel_enable && i_set_status_flag) |=> o_entry == MODE_DISABLED_EXC;
   endproperty
   a_disabled_trap: assert property (p_disabled_trap) else $error("no disabled trap");

   property p_enabled_entry;
      @(posedge i_clk) disable iff (i_reset)
         (o_cfg.hw_accel_enable && i_branch_enter_bytecode) |=> o_entry == MODE_BYTECODE;
   endproperty
   a_enabled_entry: assert property (p_enabled_entry) else $error("no bytecode entry");

   property p_obj_follow;
      @(posedge i_clk) disable iff (i_reset)
         !i_bytecode_active |=> o_cfg.object_ref_pointer == st.main_cfg[MC_OPTR_BIT];
   endproperty
   a_obj_follow: assert property (p_obj_follow) else $error("object mode stale");

   property p_idx_follow;
      @(posedge i_clk) disable iff (i_reset)
         !i_bytecode_active |=> o_cfg.field_index_wide == st.main_cfg[MC_IDX_BIT];
   endproperty
   a_idx_follow: assert property (p_idx_follow) else $error("index width stale");

   property p_static_follow;
      @(posedge i_clk) disable iff (i_reset)
         !i_bytecode_active |=> o_cfg.static_ref_pointer == st.main_cfg[MC_SPTR_BIT];
   endproperty
   a_static_follow: assert property (p_static_follow) else $error("static mode stale");

   property p_enable_follow;
      @(posedge i_clk) disable iff (i_reset)
         !i_bytecode_active |=> o_cfg.hw_accel_enable == st.main_cfg[MC_EN_BIT];
   endproperty
   a_enable_follow: assert property (p_enable_follow) else $error("enable stale");

   property p_array_data;
      @(posedge i_clk) disable iff (i_reset)
         !i_bytecode_active |=> o_cfg.array_data_offset == st.params[11:8];
   endproperty
   a_array_data: assert property (p_array_data) else $error("array offset stale");

   property p_static_off;
      @(posedge i_clk) disable iff (i_reset)
         !i_bytecode_active |=> o_cfg.static_field_offset == st.params[7:4];
   endproperty
   a_static_off: assert property (p_static_off) else $error("static offset stale");

   property p_bound_shift;
      @(posedge i_clk) disable iff (i_reset)
         !i_bytecode_active |=> o_cfg.bound_count_shift == st.params[21:17];
   endproperty
   a_bound_shift: assert property (p_bound_shift) else $error("bound shift stale");

   property p_params_write;
      @(posedge i_clk) disable iff (i_reset)
         (sel_params && i_req.write) |=> st.params == ($past(i_req.wdata) & PR_WR_MASK);
   endproperty
   a_params_write: assert property (p_params_write) else $error("params write lost");

   property p_main_read;
      @(posedge i_clk) disable iff (i_reset)
         (sel_main && !i_req.write) |=> o_rvalid && o_rdata == $past(st.main_cfg);
   endproperty
   a_main_read: assert property (p_main_read) else $error("main read wrong");

   property p_no_stray_read;
      @(posedge i_clk) disable iff (i_reset)
         !((sel_main || sel_params) && !i_req.write) |=> !o_rvalid;
   endproperty
   a_no_stray_read: assert property (p_no_stray_read) else $error("stray read answer");

   property p_rdata_hold;
      @(posedge i_clk) disable iff (i_reset)
         !((sel_main || sel_params) && !i_req.write) |=> $stable(o_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

   property p_user_undef_params;
      @(posedge i_clk) disable iff (i_reset)
         (i_req.valid && !i_req.privileged && i_req.cp_num == CP_NUM && i_req.op1 == CP_OP1
          && i_req.crn == CRN_PARAMS && i_req.crm == CRM_SEL && i_req.op2 == CP_OP2)
         |=> o_undef && !o_rvalid;
   endproperty
   a_user_undef_params: assert property (p_user_undef_params) else $error("user params open");

   property p_undef_pulse;
      @(posedge i_clk) disable iff (i_reset)
         !undef_req |=> !o_undef;
   endproperty
   a_undef_pulse: assert property (p_undef_pulse) else $error("stray undef");

   property p_disabled_branch;
      @(posedge i_clk) disable iff (i_reset)
         (!o_cfg.hw_accel_enable && i_branch_enter_bytecode && !i_set_status_flag)
            |=> o_entry == MODE_EXCHANGE;
   endproperty
   a_disabled_branch: assert property (p_disabled_branch) else $error("no exchange");

   property p_enabled_flag;
      @(posedge i_clk) disable iff (i_reset)
         (o_cfg.hw_accel_enable && i_set_status_flag) |=> o_entry == MODE_BYTECODE;
   endproperty
   a_enabled_flag: assert property (p_enabled_flag) else $error("flag did not enter");

   property p_entry_idle;
      @(posedge i_clk) disable iff (i_reset)
         (!i_branch_enter_bytecode && !i_set_status_flag) |=> o_entry == MODE_NONE;
   endproperty
   a_entry_idle: assert property (p_entry_idle) else $error("stray entry result");

   c_main_write: cover property (@(posedge i_clk) sel_main && i_req.write);
   c_params_read: cover property (@(posedge i_clk) sel_params && !i_req.write);
   c_user_trap: cover property (@(posedge i_clk) undef_req);
   c_entry: cover property (@(posedge i_clk) o_entry == MODE_BYTECODE);
   c_trap: cover property (@(posedge i_clk) o_entry == MODE_DISABLED_EXC);

endmodule : bca_config_regs
`default_nettype wire

/* File: bca_config_regs_tb_top.sv */
// Purpose : Self-checking bench for the accelerator configuration registers
// Assumes : Bench drives coprocessor requests and entry pulses at rising edges
// Notes   : Answers are collected over three cycles after the taking edge
`timescale 1ns/10ps
`default_nettype none
module bca_config_regs_tb_top;
   import bca_pkg::*;

   // ==========================================================
   // Signals
   logic        i_clk;
   logic        i_reset;
   bca_req_s    i_req;
   logic        i_bytecode_active;
   logic        i_branch_enter_bytecode;
   logic        i_set_status_flag;
   logic [31:0] o_rdata;
   logic        o_rvalid;
   logic        o_undef;
   bca_cfg_s    o_cfg;
   bca_entry_e  o_entry;
   int          bad_count;
   int          n_tests;
   logic [31:0] rd;
   logic        got_rv;
   logic        got_un;
   bca_entry_e  got_en;
   logic [31:0] mm;
   logic [31:0] pm;

   bca_config_regs i_bca_config_regs (
      .i_clk                   (i_clk),
      .i_reset                 (i_reset),
      .i_req                   (i_req),
      .i_bytecode_active       (i_bytecode_active),
      .i_branch_enter_bytecode (i_branch_enter_bytecode),
      .i_set_status_flag       (i_set_status_flag),
      .o_rdata                 (o_rdata),
      .o_rvalid                (o_rvalid),
      .o_undef                 (o_undef),
      .o_cfg                   (o_cfg),
      .o_entry                 (o_entry)
   );

   // ==========================================================
   // Clock
   always #12.5 i_clk = ~i_clk;

   // ==========================================================
   // Helpers
   function automatic bca_req_s mk(input logic wr, input logic pv, input logic [3:0] crn,
                                   input logic [31:0] wd);
      mk = '{valid: 1'b1, write: wr, privileged: pv, cp_num: CP_NUM, op1: CP_OP1,
             crn: crn, crm: CRM_SEL, op2: CP_OP2, wdata: wd};
   endfunction : mk

   function automatic logic [31:0] exp_cfg(input logic [31:0] m, input logic [31:0] p);
      exp_cfg = {3'h0, m[31], 1'b0, m[29], m[28], m[27], m[26], m[0],
                 p[21:17], p[16:12], p[11:8], p[7:4], p[3:0]};
   endfunction : exp_cfg

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic pv, input logic [3:0] crn,
                      input logic [31:0] wd);
      @(posedge i_clk);
      i_req <= mk(wr, pv, crn, wd);
      @(posedge i_clk);
      i_req.valid <= 1'b0;
      got_rv = 1'b0;
      got_un = 1'b0;
      repeat (3) begin
         #1;
         if (o_rvalid === 1'b1) begin
            got_rv = 1'b1;
            rd = o_rdata;
         end
         if (o_undef === 1'b1) got_un = 1'b1;
         @(posedge i_clk);
      end
      #1;
   endtask : bus

   task automatic rd_chk(input logic [3:0] crn, input logic [31:0] exp);
      bus(1'b0, 1'b1, crn, 32'h00000000);
      chk("rvalid", 32'h1, {31'h0, got_rv});
      chk("rdata", exp, rd);
      chk("cfg", exp_cfg(mm, pm), {3'h0, o_cfg});
   endtask : rd_chk

   task automatic pulse(input logic br, input logic fl, input bca_entry_e exp);
      @(posedge i_clk);
      i_branch_enter_bytecode <= br;
      i_set_status_flag <= fl;
      @(posedge i_clk);
      i_branch_enter_bytecode <= 1'b0;
      i_set_status_flag <= 1'b0;
      got_en = MODE_NONE;
      repeat (3) begin
         #1;
         if (o_entry !== MODE_NONE) got_en = o_entry;
         @(posedge i_clk);
      end
      chk("entry", {30'h0, exp}, {30'h0, got_en});
   endtask : pulse

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd_chk(CRN_MAIN, 32'h00000000);
      rd_chk(CRN_PARAMS, 32'h00000000);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_main;
      mm = 32'hA4000001;
      bus(1'b1, 1'b1, CRN_MAIN, 32'hA4000001);
      rd_chk(CRN_MAIN, 32'hA4000001);
      mm = 32'h18000000;
      bus(1'b1, 1'b1, CRN_MAIN, 32'h5BFFFFFE);
      rd_chk(CRN_MAIN, 32'h18000000);
      $display("t_main done");
   endtask : t_main

   task automatic t_params;
      logic [31:0] wd;
      wd = {10'h3FF, 5'h13, 5'h1A, 4'h5, 4'hC, 4'h3};
      pm = {10'h000, wd[21:0]};
      bus(1'b1, 1'b1, CRN_PARAMS, wd);
      rd_chk(CRN_PARAMS, pm);
      $display("t_params done");
   endtask : t_params

   task automatic t_user;
      bus(1'b1, 1'b0, CRN_MAIN, 32'hFFFFFFFF);
      chk("undef_wr", 32'h1, {31'h0, got_un});
      bus(1'b0, 1'b0, CRN_PARAMS, 32'h00000000);
      chk("undef_rd", 32'h1, {31'h0, got_un});
      chk("rv_user", 32'h0, {31'h0, got_rv});
      bus(1'b0, 1'b1, 4'h4, 32'h00000000);
      chk("rv_unmap", 32'h0, {31'h0, got_rv});
      chk("un_unmap", 32'h0, {31'h0, got_un});
      rd_chk(CRN_MAIN, 32'h18000000);
      $display("t_user done");
   endtask : t_user

   task automatic t_freeze;
      @(posedge i_clk);
      i_bytecode_active <= 1'b1;
      bus(1'b1, 1'b1, CRN_MAIN, 32'h00000000);
      chk("cfg_frozen", exp_cfg(mm, pm), {3'h0, o_cfg});
      @(posedge i_clk);
      i_bytecode_active <= 1'b0;
      mm = 32'h00000000;
      repeat (3) @(posedge i_clk);
      #1;
      chk("cfg_after", exp_cfg(mm, pm), {3'h0, o_cfg});
      $display("t_freeze done");
   endtask : t_freeze

   task automatic t_entry;
      pulse(1'b1, 1'b0, MODE_EXCHANGE);
      pulse(1'b0, 1'b1, MODE_DISABLED_EXC);
      pulse(1'b1, 1'b1, MODE_DISABLED_EXC);
      mm = 32'h00000001;
      bus(1'b1, 1'b1, CRN_MAIN, 32'h00000001);
      pulse(1'b1, 1'b0, MODE_BYTECODE);
      pulse(1'b0, 1'b1, MODE_BYTECODE);
      $display("t_entry done");
   endtask : t_entry

   // ==========================================================
   // Verdict
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      i_clk = 1'b0;
      i_reset = 1'b1;
      i_req = '0;
      i_bytecode_active = 1'b0;
      i_branch_enter_bytecode = 1'b0;
      i_set_status_flag = 1'b0;
      bad_count = 0;
      n_tests = 0;
      rd = 32'h0;
      mm = 32'h0;
      pm = 32'h0;
      repeat (8) @(posedge i_clk);
      i_reset <= 1'b0;
      t_reset();
      t_main();
      t_params();
      t_user();
      t_freeze();
      t_entry();
      give_verdict();
   end

   // Tests need about 110 cycles; a generous margin cuts a hang
   initial begin
      repeat (2000) @(posedge i_clk);
      bad_count++;
      give_verdict();
   end

endmodule : bca_config_regs_tb_top
`default_nettype wire
